// [common/ist_pkg.sv]
// constants and types shared by the slave transmit block
// assumes one system clock domain and one free-running link sampling clock
package ist_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int CNT_W = 4;
  localparam int SEL_W = 4;
  // bit counter values
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] ADDR_LAST_CNT = 4'h8; // 8 address bits seen, checked at the 8th falling edge
  localparam logic [CNT_W-1:0] TX_LAST_BIT = 4'h7;
  // read/write bit position inside the address frame
  localparam int RW_POS = 0;
  localparam logic RW_READ = 1'h1;
  // synchroniser width in the link domain: pins, toggles, config
  localparam int LSYNC_W = 4 + 2 + ADDR_W;
  // cpu domain synchroniser width: three event toggles
  localparam int CSYNC_W = 3;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_LOAD = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } ist_state_t;
endpackage

// [src/ist_slave_tx.sv]
// slave transmit path of the two-wire bus interface
// assumes an external master clocks scl; link_clk samples the pins freely
`timescale 1ns/1ps
//
// Contract
// R1: device drives data, master clocks and acks
// R2: software enables, selects clock, slave receive
// R3: matched address gets programmed ack level
// R4: read bit sets transmit select and empty
// R5: software writes next byte on empty
// R6: end flag sets with empty held, software clears
// R7: clear select, dummy read releases scl
// R8: end flag at ack end without byte
module ist_slave_tx
  import ist_pkg::*;
(
  // system side
  input wire logic clock,
  input wire logic sys_rst,
  // link sampling clock
  input wire logic link_clk,
  // configuration levels
  input wire logic bus_if_enable,
  input wire logic master_select,
  input wire logic [SEL_W-1:0] transfer_clock_select,
  input wire logic ack_bit_level,
  input wire logic [ADDR_W-1:0] own_addr,
  // software strobes, one clock each
  input wire logic tx_wr,
  input wire logic [DATA_W-1:0] tx_wdata,
  input wire logic rx_rd,
  input wire logic select_clr,
  input wire logic empty_clr,
  input wire logic end_clr,
  // status
  output logic transmit_select,
  output logic tx_data_empty_flag,
  output logic tx_end_flag,
  output logic [DATA_W-1:0] rx_data_reg,
  output logic [SEL_W-1:0] clock_select_reg,
  // open-drain pins, enable low means pulling low
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n
);
  typedef struct packed {
    logic sel;
    logic empty;
    logic done;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] rx_data;
    logic [SEL_W-1:0] clk_sel;
    logic req_t;
    logic rel_t;
    logic match_seen;
    logic ack_seen;
    logic end_seen;
  } ist_cpu_t;

  typedef struct packed {
    ist_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] addr;
    logic scl_p;
    logic sda_p;
    logic acked;
    logic scl_oe_n;
    logic sda_oe_n;
    logic match_t;
    logic ack_t;
    logic end_t;
    logic rel_seen;
    logic rst_p;
  } ist_link_t;

  ist_cpu_t cs;
  ist_cpu_t next_cs;
  ist_link_t ls;
  ist_link_t next_ls;
  logic [LSYNC_W-1:0] lsync;
  logic [CSYNC_W-1:0] csync;
  logic [1:0] lrst_sync;

  // config levels are quasi-static: software sets them before a transfer
  ist_sync #(.WIDTH(LSYNC_W)) u_lsync (
    .clk(link_clk),
    .din({scl_in, sda_in, cs.req_t, cs.rel_t,
          bus_if_enable & ~master_select, ack_bit_level, own_addr}),
    .dout(lsync)
  );

  ist_sync #(.WIDTH(CSYNC_W)) u_csync (
    .clk(clock),
    .din({ls.match_t, ls.ack_t, ls.end_t}),
    .dout(csync)
  );

  // reset reaches the link domain through its own synchroniser
  ist_sync #(.WIDTH(2)) u_rsync (
    .clk(link_clk),
    .din({sys_rst, sys_rst}),
    .dout(lrst_sync)
  );

  logic l_scl;
  logic l_sda;
  logic l_req;
  logic l_rel;
  logic l_en;
  logic l_ackbit;
  logic [ADDR_W-1:0] l_own;
  assign {l_scl, l_sda, l_req, l_rel, l_en, l_ackbit, l_own} = lsync;

  // link domain: bit engine on sampled scl/sda
  always_comb begin
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    rise = 1'h0;
    fall = 1'h0;
    start_c = 1'h0;
    stop_c = 1'h0;
    next_ls = ls;
    next_ls.scl_p = l_scl;
    next_ls.sda_p = l_sda;
    next_ls.rst_p = lrst_sync[0];
    rise = l_scl & ~ls.scl_p;
    fall = ~l_scl & ls.scl_p;
    start_c = l_scl & ls.scl_p & ls.sda_p & ~l_sda;
    stop_c = l_scl & ls.scl_p & ~ls.sda_p & l_sda;
    if (!l_en || stop_c) begin
      next_ls.state = ST_IDLE;
      next_ls.scl_oe_n = 1'h1;
      next_ls.sda_oe_n = 1'h1;
    end else if (start_c) begin
      next_ls.state = ST_ADDR;
      next_ls.cnt = CNT_ZERO;
      next_ls.scl_oe_n = 1'h1;
      next_ls.sda_oe_n = 1'h1;
    end else if (l_rel != ls.rel_seen) begin
      // dummy read lets go of scl and ends our part of the frame
      next_ls.rel_seen = l_rel; // R7
      next_ls.state = ST_IDLE;
      next_ls.scl_oe_n = 1'h1;
      next_ls.sda_oe_n = 1'h1;
    end else begin
      case (ls.state)
        ST_ADDR: begin
          if (rise) begin
            next_ls.addr = {ls.addr[DATA_W-2:0], l_sda};
            next_ls.cnt = ls.cnt + CNT_ONE;
          end else if (fall && ls.cnt == ADDR_LAST_CNT) begin
            if (ls.addr[DATA_W-1:1] == l_own) begin
              // level stands before the 9th rising edge
              next_ls.sda_oe_n = l_ackbit; // R3
              next_ls.match_t = ~ls.match_t;
              next_ls.state = ST_AACK;
            end else begin
              next_ls.state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            next_ls.sda_oe_n = 1'h1;
            if (ls.addr[RW_POS] == RW_READ && !l_ackbit) begin
              next_ls.state = ST_LOAD;
              next_ls.scl_oe_n = 1'h0;
            end else begin
              next_ls.state = ST_IDLE;
            end
          end
        end
        ST_LOAD: begin
          // scl is held low until a byte is handed over
          if (l_req != ls.ack_t) begin
            next_ls.sh = cs.tx_data;
            next_ls.ack_t = l_req;
            next_ls.cnt = CNT_ZERO;
            next_ls.sda_oe_n = cs.tx_data[DATA_W-1]; // R1
            next_ls.scl_oe_n = 1'h1;
            next_ls.state = ST_TX;
          end else begin
            next_ls.scl_oe_n = 1'h0;
          end
        end
        ST_TX: begin
          if (fall) begin
            if (ls.cnt == TX_LAST_BIT) begin
              next_ls.sda_oe_n = 1'h1;
              next_ls.state = ST_MACK;
            end else begin
              next_ls.sh = {ls.sh[DATA_W-2:0], 1'h0};
              next_ls.sda_oe_n = ls.sh[DATA_W-2]; // R1
              next_ls.cnt = ls.cnt + CNT_ONE;
            end
          end
        end
        ST_MACK: begin
          // the master answers the byte; sample at the rise, act at the fall
          if (rise) begin
            next_ls.acked = ~l_sda; // R1
          end else if (fall) begin
            next_ls.end_t = ~ls.end_t; // R8
            if (ls.acked) begin
              next_ls.state = ST_LOAD;
              next_ls.scl_oe_n = l_req != ls.ack_t;
            end else begin
              next_ls.state = ST_IDLE;
            end
          end
        end
        default: begin
          next_ls.state = ST_IDLE;
          next_ls.scl_oe_n = 1'h1;
          next_ls.sda_oe_n = 1'h1;
        end
      endcase
    end
    if (ls.rst_p) begin
      next_ls = '0;
      next_ls.state = ST_IDLE;
      next_ls.scl_oe_n = 1'h1;
      next_ls.sda_oe_n = 1'h1;
      next_ls.scl_p = l_scl;
      next_ls.sda_p = l_sda;
      next_ls.rst_p = lrst_sync[0];
      // toggles realign with the cpu side after reset
      next_ls.ack_t = l_req;
      next_ls.rel_seen = l_rel;
    end
  end

  // registers the whole link state
  always_ff @(posedge link_clk) begin
    ls <= next_ls;
  end

  logic c_match;
  logic c_ack;
  logic c_end;
  assign {c_match, c_ack, c_end} = csync;

  // cpu domain: flags; clears go first so a same-cycle set wins
  always_comb begin
    logic pending;
    pending = 1'h0;
    next_cs = cs;
    pending = cs.req_t != cs.ack_seen;
    next_cs.clk_sel = transfer_clock_select;
    if (select_clr) begin
      next_cs.sel = 1'h0; // R7
    end
    if (empty_clr) begin
      next_cs.empty = 1'h0; // R7
    end
    if (end_clr) begin
      next_cs.done = 1'h0; // R6
    end
    if (rx_rd) begin
      next_cs.rel_t = ~cs.rel_t; // R7
    end
    // writes while a byte waits would corrupt it in flight; refused
    if (tx_wr && !pending) begin
      next_cs.tx_data = tx_wdata; // R5
      next_cs.req_t = ~cs.req_t;
      next_cs.empty = 1'h0;
    end
    if (c_match != cs.match_seen) begin
      next_cs.match_seen = c_match;
      next_cs.rx_data = ls.addr;
      if (ls.addr[RW_POS] == RW_READ) begin
        next_cs.sel = 1'h1; // R4
        next_cs.empty = 1'h1; // R4
      end
    end
    if (c_ack != cs.ack_seen) begin
      next_cs.ack_seen = c_ack;
      next_cs.empty = 1'h1; // R5
    end
    if (c_end != cs.end_seen) begin
      next_cs.end_seen = c_end;
      if (cs.empty && !pending) begin
        next_cs.done = 1'h1; // R6
      end
    end
    if (sys_rst) begin
      next_cs = '0;
      next_cs.match_seen = c_match;
      next_cs.ack_seen = c_ack;
      next_cs.end_seen = c_end;
      next_cs.req_t = c_ack;
    end
  end

  // registers the whole cpu-side state
  always_ff @(posedge clock) begin
    cs <= next_cs;
  end

  // outputs come straight from state flops, except scl_out and sda_out, which are tied low
  assign transmit_select = cs.sel;
  assign tx_data_empty_flag = cs.empty;
  assign tx_end_flag = cs.done;
  assign rx_data_reg = cs.rx_data;
  assign clock_select_reg = cs.clk_sel;
  assign scl_oe_n = ls.scl_oe_n;
  assign sda_oe_n = ls.sda_oe_n;
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
endmodule

// [src/ist_sync.sv]
// two-flop synchroniser bank for levels and toggles
// assumes every bit is independent or quasi-static while it changes
`timescale 1ns/1ps
module ist_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input wire logic clk,
  // source side and synchronised result
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ist_sync_st_t;

  ist_sync_st_t st;
  ist_sync_st_t next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  // no reset: a synchroniser settles after two edges anyway
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign dout = st.stable;
endmodule

// [verification/ist_master.sv]
// behavioural bus master that clocks and acknowledges the slave
// assumes the bench resolves both open-drain wires with a pull-up
`timescale 1ns/1ps
module ist_master (
  // resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // master pull-downs, 1 releases the wire
  output logic scl_m,
  output logic sda_m
);
  localparam time Q = 125ns;
  logic s;
  initial begin
    scl_m = 1'h1;
    sda_m = 1'h1;
  end
  // one clock; waits out stretching, bounded so a stuck slave cannot hang us
  task automatic pulse(output logic v);
    #Q scl_m = 1'h1;
    for (int n = 0; n < 400 && scl !== 1'h1; n++) #10;
    #Q v = sda;
    scl_m = 1'h0;
    #Q;
  endtask
  // raise data then clock so a repeated start follows a low clock cleanly
  task automatic start();
    #Q sda_m = 1'h1;
    #Q scl_m = 1'h1;
    #Q sda_m = 1'h0;
    #Q scl_m = 1'h0;
  endtask
  // data rises while the clock stays high, leaving both wires free
  task automatic stop();
    sda_m = 1'h0;
    #Q scl_m = 1'h1;
    #Q sda_m = 1'h1;
    #Q;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m = d[i];
      pulse(s);
    end
    sda_m = 1'h1;
    pulse(ack);
  endtask
  task automatic get_byte(output logic [7:0] d, input logic ak);
    sda_m = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i]);
    end
    sda_m = ak;
    pulse(s);
    sda_m = 1'h1;
  endtask
endmodule

// [verification/ist_slave_tx_sva.sv]
// port assertions for the slave transmit block
// assumes binding into ist_slave_tx with reset held over both clocks
`timescale 1ns/1ps
module ist_slave_tx_sva (
  // clocks and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  // strobes and flags
  input wire logic tx_wr,
  input wire logic rx_rd,
  input wire logic select_clr,
  input wire logic end_clr,
  input wire logic transmit_select,
  input wire logic tx_data_empty_flag,
  input wire logic tx_end_flag,
  // pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  // cpu side flags
  select_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(transmit_select) |-> ##[0:2] tx_data_empty_flag) else $error("select without empty");
  wr_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
    tx_wr && tx_data_empty_flag |=> !tx_data_empty_flag) else $error("write kept empty");
  end_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(tx_end_flag) |-> tx_data_empty_flag) else $error("end flag without empty");
  end_clr_a: assert property (@(posedge clock) disable iff (sys_rst)
    end_clr |=> !tx_end_flag) else $error("end flag not cleared");
  select_clr_a: assert property (@(posedge clock) disable iff (sys_rst)
    select_clr |=> !transmit_select) else $error("select not cleared");
  scl_free_a: assert property (@(posedge clock) disable iff (sys_rst)
    rx_rd |-> ##[1:8] scl_oe_n) else $error("clock line not released");
  // pin side: data moves and the clock is pulled only while the clock line is low; driven levels are low
  sda_move_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $changed(sda_oe_n) |-> !scl_in) else $error("data moved with clock high");
  scl_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(scl_oe_n) |-> !scl_in) else $error("clock pulled while high");
  pins_low_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !scl_out && !sda_out) else $error("open drain level not low");
  // main scenarios
  cover property (@(posedge clock) $rose(transmit_select));
  cover property (@(posedge clock) $rose(tx_end_flag));
  cover property (@(posedge link_clk) $fell(sda_oe_n));
endmodule
bind ist_slave_tx ist_slave_tx_sva chk (.clock, .sys_rst, .link_clk, .tx_wr, .rx_rd,
  .select_clr, .end_clr, .transmit_select, .tx_data_empty_flag, .tx_end_flag, .scl_in,
  .scl_out, .scl_oe_n, .sda_out, .sda_oe_n);

// [verification/tb_ist_slave_tx.sv]
// self-checking bench for the slave transmit path
// assumes the package, design sources and master model compile ahead
`timescale 1ns/1ps
module tb_ist_slave_tx;
  import ist_pkg::*;
  logic clock = 1'h0;
  logic link_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [4:0] strb = 5'h00;
  logic [DATA_W-1:0] tx_wdata = 8'h00;
  logic [ADDR_W-1:0] own_addr = 7'h5a;
  logic [SEL_W-1:0] transfer_clock_select = 4'ha;
  logic bus_if_enable = 1'h1;
  logic master_select = 1'h0;
  logic ack_bit_level = 1'h0;
  logic transmit_select, tx_data_empty_flag, tx_end_flag, ack;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m;
  logic [DATA_W-1:0] rx_data_reg, b;
  logic [SEL_W-1:0] clock_select_reg;
  int failures = 0;
  int cmp_count = 0;
  // open-drain wires with pull-up
  wire scl = scl_m & (scl_oe_n | scl_out);
  wire sda = sda_m & (sda_oe_n | sda_out);
  always #25 clock = ~clock;
  // link clock offset so its edges drift against the system clock
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  ist_slave_tx dut (.clock, .sys_rst, .link_clk, .bus_if_enable, .master_select,
    .transfer_clock_select, .ack_bit_level, .own_addr, .tx_wr(strb[4]), .tx_wdata,
    .rx_rd(strb[3]), .select_clr(strb[2]), .empty_clr(strb[1]), .end_clr(strb[0]),
    .transmit_select, .tx_data_empty_flag, .tx_end_flag, .rx_data_reg, .clock_select_reg,
    .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe_n, .sda_out, .sda_oe_n);
  ist_master m (.scl, .sda, .scl_m, .sda_m);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle software strobe, then time for the crossing to settle
  task automatic strobe(input logic [4:0] s, input logic [7:0] d);
    @(negedge clock);
    strb = s;
    tx_wdata = d;
    @(negedge clock);
    strb = 5'h00;
    repeat (6) @(negedge clock);
  endtask
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'h0;
    repeat (4) @(negedge clock);
    chk({transmit_select, tx_data_empty_flag, tx_end_flag, scl_oe_n, sda_oe_n}, 8'h03);
    chk(clock_select_reg, 8'h0a);
    chk({scl_out, sda_out}, 8'h00);
    m.start();
    m.put_byte({7'h33, 1'h1}, ack);
    m.stop();
    chk({ack, transmit_select}, 8'h02);
    m.start();
    m.put_byte({own_addr, 1'h0}, ack);
    m.stop();
    chk({ack, transmit_select}, 8'h00);
    m.start();
    m.put_byte({own_addr, 1'h1}, ack);
    chk(ack, 8'h00);
    repeat (6) @(negedge clock);
    chk({transmit_select, tx_data_empty_flag, scl_oe_n}, 8'h06);
    chk(rx_data_reg, {own_addr, 1'h1});
    strobe(5'h10, 8'ha5);
    for (int i = 0; i < 40 && tx_data_empty_flag !== 1'h1; i++) @(negedge clock);
    strobe(5'h10, 8'h3c);
    m.get_byte(b, 1'h0);
    repeat (8) @(negedge clock);
    chk({b, tx_end_flag}, {8'ha5, 1'h0});
    m.get_byte(b, 1'h0);
    repeat (8) @(negedge clock);
    chk(b, 8'h3c);
    chk({tx_end_flag, tx_data_empty_flag, scl_oe_n}, 8'h06);
    strobe(5'h01, 8'h00);
    chk(tx_end_flag, 8'h00);
    strobe(5'h04, 8'h00);
    chk(transmit_select, 8'h00);
    strobe(5'h08, 8'h00);
    chk(scl_oe_n, 8'h01);
    strobe(5'h02, 8'h00);
    chk(tx_data_empty_flag, 8'h00);
    m.stop();
    // a programmed ack level of one answers the address with no ack
    @(negedge clock);
    ack_bit_level = 1'h1;
    m.start();
    m.put_byte({own_addr, 1'h0}, ack);
    m.stop();
    chk({ack, sda_oe_n}, 8'h03);
    // master mode selected: the slave path must ignore its own address
    @(negedge clock);
    ack_bit_level = 1'h0;
    master_select = 1'h1;
    m.start();
    m.put_byte({own_addr, 1'h1}, ack);
    m.stop();
    repeat (6) @(negedge clock);
    chk({ack, transmit_select}, 8'h02);
    give_verdict();
  end
endmodule
